// ---- hdl/scc_pkg.sv ----
// shared constants, types and timing counts for the clock-config register bank
//==========================================================================
// Contract
// - registers are 1 or 2 bytes wide
// - host reads multibyte low byte first
// - low byte read freezes upper bytes
// - host writes multibyte bytes in ascending order
// - multibyte write commits on top byte
// - event register bits clear on written ones
// - role status shows both role pins
// - primary skew is 12 bits, resets zero
// - secondary skew 12 bits at 0x07/0x08
// - fill window 4 bits, default one
// - leak ratio 4 bits, default three
// - capacity 6 bits, default 20, >= raise
// - raise 6 bits, default 15, ordered
// - clear 6 bits, default 10, < raise
// - ordering-breaking threshold writes are dropped
// - host latches address with ALE first
// - device holds ready low at least 50 ns
// - device drives ready only while selected
package scc_pkg;
   //==========================================================================
   // register offsets
   localparam logic [7:0] ADDR_ID_LO      = 8'h00;
   localparam logic [7:0] ADDR_ID_HI      = 8'h01;
   localparam logic [7:0] ADDR_REV        = 8'h02;
   localparam logic [7:0] ADDR_SUBREV     = 8'h03;
   localparam logic [7:0] ADDR_ROLE       = 8'h04;
   localparam logic [7:0] ADDR_PSKEW_LO   = 8'h05;
   localparam logic [7:0] ADDR_PSKEW_HI   = 8'h06;
   localparam logic [7:0] ADDR_SSKEW_LO   = 8'h07;
   localparam logic [7:0] ADDR_SSKEW_HI   = 8'h08;
   localparam logic [7:0] ADDR_FILL       = 8'h09;
   localparam logic [7:0] ADDR_LEAK       = 8'h0A;
   localparam logic [7:0] ADDR_CAP        = 8'h0B;
   localparam logic [7:0] ADDR_RAISE      = 8'h0C;
   localparam logic [7:0] ADDR_CLEAR      = 8'h0D;
   localparam logic [7:0] ADDR_EVENT_LO   = 8'h5E;
   localparam logic [7:0] ADDR_EVENT_HI   = 8'h5F;
   //==========================================================================
   // reset values
   localparam logic [11:0] RST_SKEW       = 12'h000;
   localparam logic [3:0]  RST_FILL       = 4'h1;
   localparam logic [3:0]  RST_LEAK       = 4'h3;
   localparam logic [5:0]  RST_CAP        = 6'h14;
   localparam logic [5:0]  RST_RAISE      = 6'h0F;
   localparam logic [5:0]  RST_CLEAR      = 6'h0A;
   // device pin filter at rest {ale, cs_n, wr_n, rd_n, ad, role, act}: deselected, lines pulled high
   localparam logic [14:0] PIN_IDLE       = 15'h3FF8;
   // event bit positions
   localparam int EV_ALARM_ON             = 0;
   localparam int EV_ALARM_OFF            = 1;
   localparam int EV_ROLE_CHG             = 2;
   //==========================================================================
   // timing, 25 MHz clock
   localparam int CLK_PERIOD_NS           = 40;
   localparam int T_RDY_LOW_NS            = 50;
   localparam int RDY_LOW_CYC             = (T_RDY_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_CS_GAP_NS             = 50;
   localparam int CS_GAP_CYC              = (T_CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_MS_NS                 = 1000000;
   localparam int CYC_PER_MS_DEF          = T_MS_NS / CLK_PERIOD_NS;
   // pins cross a 3-flop filter, so every pin phase is held this long
   localparam int PIN_HOLD_CYC            = 3;
   //==========================================================================
   // state machines
   typedef enum logic [1:0] {DS_IDLE, DS_LOW, DS_HOLD} scc_dev_st_e;
   typedef enum logic [2:0] {HS_IDLE, HS_ALE, HS_AHOLD, HS_SETUP, HS_WAITLO, HS_WAITHI, HS_CSH, HS_GAP}
      scc_host_st_e;
endpackage : scc_pkg

// ---- hdl/scc_bus_if.sv ----
// multiplexed address/data bus between host and device
`timescale 1ns/100ps
interface scc_bus_if;
   logic       ale;
   logic       cs_n;
   logic       write_strobe_n;
   logic       read_strobe_n;
   logic [7:0] ad_h;
   logic       ad_h_oe;
   logic [7:0] ad_d;
   logic       ad_d_oe;
   logic       rdy_d;
   logic       rdy_d_oe;
   logic [7:0] ad;
   logic       rdy;
   // wire levels; undriven lines float high through pull-ups
   assign ad  = ad_d_oe ? ad_d : (ad_h_oe ? ad_h : 8'hFF);
   assign rdy = rdy_d_oe ? rdy_d : 1'b1;
   modport dev  (input ale, cs_n, write_strobe_n, read_strobe_n, ad, output ad_d, ad_d_oe, rdy_d, rdy_d_oe);
   modport host (output ale, cs_n, write_strobe_n, read_strobe_n, ad_h, ad_h_oe, input ad, rdy);
endinterface : scc_bus_if

// ---- hdl/scc_bucket.sv ----
// leaky-bucket reference activity monitor
`timescale 1ns/100ps
module scc_bucket #(
   parameter int unsigned CYC_PER_MS = scc_pkg::CYC_PER_MS_DEF
) (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       act_i,
   input  wire logic [3:0] fill_i,
   input  wire logic [3:0] leak_i,
   input  wire logic [5:0] cap_i,
   input  wire logic [5:0] raise_i,
   input  wire logic [5:0] clear_i,
   output logic            alarm_o
);
   import scc_pkg::*;
   logic [31:0] ms_q;
   logic [3:0]  fill_q;
   logic [3:0]  leak_q;
   logic        seen_q;
   logic [5:0]  lvl_q;
   logic        ms_end;
   logic        fill_end;
   logic        leak_end;
   logic [6:0]  sum;

   assign ms_end   = (ms_q == CYC_PER_MS - 1);
   assign fill_end = ms_end && (fill_q == fill_i);
   assign leak_end = fill_end && (leak_q == leak_i);
   // a quiet fill window adds one, a leak window removes one unless the count is zero
   assign sum = {1'b0, lvl_q} + {6'h00, (fill_end && !seen_q)} - {6'h00, (leak_end && lvl_q != 6'h00)};

   // window counters
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ms_q   <= '0;
         fill_q <= '0;
         leak_q <= '0;
         seen_q <= 1'b0;
      end else begin
         ms_q   <= ms_end ? '0 : ms_q + 32'd1;
         seen_q <= fill_end ? act_i : (seen_q | act_i);
         if (ms_end) begin
            fill_q <= fill_end ? 4'h0 : fill_q + 4'h1;
         end
         if (fill_end) begin
            leak_q <= leak_end ? 4'h0 : leak_q + 4'h1;
         end
      end
   end

   // count saturates at capacity, also when capacity is lowered later
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         lvl_q <= '0;
      end else if (sum > {1'b0, cap_i}) begin
         lvl_q <= cap_i;
      end else begin
         lvl_q <= sum[5:0];
      end
   end

   // hysteresis alarm
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         alarm_o <= 1'b0;
      end else if (lvl_q >= raise_i) begin
         alarm_o <= 1'b1;
      end else if (lvl_q <= clear_i) begin
         alarm_o <= 1'b0;
      end
   end
endmodule : scc_bucket

// ---- hdl/scc_dev.sv ----
// device end: multiplexed bus slave and register bank
`timescale 1ns/100ps
module scc_dev #(
   parameter int unsigned CYC_PER_MS = scc_pkg::CYC_PER_MS_DEF,
   parameter logic [15:0] DEVICE_ID  = 16'hA5C3,   // arbitrary value
   parameter logic [7:0]  SI_REV     = 8'h07,      // arbitrary value
   parameter logic [7:0]  SI_SUBREV  = 8'h02       // arbitrary value
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   scc_bus_if.dev           bus,
   input  wire logic [1:0]  role_select_pins_i,
   input  wire logic        activity_i,
   output logic [11:0]      primary_skew_o,
   output logic [11:0]      secondary_skew_o,
   output logic             alarm_o,
   output logic [15:0]      event_o
);
   import scc_pkg::*;
   //==========================================================================
   // pin filter: {ale, cs_n, wr_n, rd_n, ad, role, activity}
   logic [14:0] s1_q;
   logic [14:0] s2_q;
   logic [14:0] s3_q;
   logic [14:0] f_q;
   logic [14:0] fp_q;
   logic        ale_f;
   logic        cs_f;
   logic        wr_f;
   logic        rd_f;
   logic [7:0]  ad_f;
   logic [1:0]  role_f;
   logic        act_f;

   // a bit changes only once the second and third flop agree
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         f_q  <= PIN_IDLE;
         fp_q <= PIN_IDLE;
      end else begin
         s1_q <= {bus.ale, bus.cs_n, bus.write_strobe_n, bus.read_strobe_n, bus.ad,
                  role_select_pins_i, activity_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q  <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
         fp_q <= f_q;
      end
   end
   assign {ale_f, cs_f, wr_f, rd_f, ad_f, role_f, act_f} = f_q;

   //==========================================================================
   // strobe decode
   logic wr_fall;
   logic rd_fall;
   assign wr_fall = !cs_f && !wr_f && fp_q[12];
   assign rd_fall = !cs_f && !rd_f && fp_q[11];

   // multibyte halves
   function automatic logic is_lsb(input logic [7:0] a);
      return a == ADDR_ID_LO || a == ADDR_PSKEW_LO || a == ADDR_SSKEW_LO || a == ADDR_EVENT_LO;
   endfunction : is_lsb
   function automatic logic is_msb(input logic [7:0] a);
      return a == ADDR_ID_HI || a == ADDR_PSKEW_HI || a == ADDR_SSKEW_HI || a == ADDR_EVENT_HI;
   endfunction : is_msb

   //==========================================================================
   // registers
   logic [7:0]  addr_q;
   logic [7:0]  whold_q;
   logic [7:0]  rhold_q;
   logic [7:0]  rdata_q;
   logic [11:0] pskew_q;
   logic [11:0] sskew_q;
   logic [3:0]  fill_q;
   logic [3:0]  leak_q;
   logic [5:0]  cap_q;
   logic [5:0]  raise_q;
   logic [5:0]  clear_q;
   logic [15:0] event_q;
   logic [5:0]  wv;
   logic [15:0] wword;
   logic        alarm;
   logic        alarm_p_q;

   assign wv    = ad_f[5:0];
   assign wword = {ad_f, whold_q};

   // address is taken while the latch strobe is high
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         addr_q <= '0;
      end else if (ale_f) begin
         addr_q <= ad_f;
      end
   end

   // low byte parks in the write holding register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         whold_q <= '0;
      end else if (wr_fall && is_lsb(addr_q)) begin
         whold_q <= ad_f;
      end
   end

   // writable settings; identity and role addresses ignore writes
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pskew_q <= RST_SKEW;
         sskew_q <= RST_SKEW;
         fill_q  <= RST_FILL;
         leak_q  <= RST_LEAK;
         cap_q   <= RST_CAP;
         raise_q <= RST_RAISE;
         clear_q <= RST_CLEAR;
      end else if (wr_fall) begin
         case (addr_q)
            ADDR_PSKEW_HI: pskew_q <= wword[11:0];
            ADDR_SSKEW_HI: sskew_q <= wword[11:0];
            ADDR_FILL:     fill_q  <= ad_f[3:0];
            ADDR_LEAK:     leak_q  <= ad_f[3:0];
            ADDR_CAP: begin
               if (wv >= raise_q) cap_q <= wv;
            end
            ADDR_RAISE: begin
               if (wv > clear_q && wv <= cap_q) raise_q <= wv;
            end
            ADDR_CLEAR: begin
               if (wv < raise_q) clear_q <= wv;
            end
            default: ;
         endcase
      end
   end

   // events: a set in the same cycle as its clear wins
   logic [15:0] ev_set;
   logic [15:0] ev_clr;
   always_comb begin
      ev_set = '0;
      ev_set[EV_ALARM_ON]  = alarm && !alarm_p_q;
      ev_set[EV_ALARM_OFF] = !alarm && alarm_p_q;
      ev_set[EV_ROLE_CHG]  = role_f != fp_q[2:1];
      ev_clr = (wr_fall && addr_q == ADDR_EVENT_HI) ? wword : 16'h0000;
   end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         event_q   <= '0;
         alarm_p_q <= 1'b0;
      end else begin
         event_q   <= (event_q & ~ev_clr) | ev_set;
         alarm_p_q <= alarm;
      end
   end

   // read mux; a low-byte read freezes the upper byte
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_q <= '0;
         rhold_q <= '0;
      end else if (rd_fall) begin
         case (addr_q)
            ADDR_ID_LO: begin
               rdata_q <= DEVICE_ID[7:0];
               rhold_q <= DEVICE_ID[15:8];
            end
            ADDR_REV:      rdata_q <= SI_REV;
            ADDR_SUBREV:   rdata_q <= SI_SUBREV;
            ADDR_ROLE:     rdata_q <= {6'h00, role_f};
            ADDR_PSKEW_LO: begin
               rdata_q <= pskew_q[7:0];
               rhold_q <= {4'h0, pskew_q[11:8]};
            end
            ADDR_SSKEW_LO: begin
               rdata_q <= sskew_q[7:0];
               rhold_q <= {4'h0, sskew_q[11:8]};
            end
            ADDR_FILL:     rdata_q <= {4'h0, fill_q};
            ADDR_LEAK:     rdata_q <= {4'h0, leak_q};
            ADDR_CAP:      rdata_q <= {2'h0, cap_q};
            ADDR_RAISE:    rdata_q <= {2'h0, raise_q};
            ADDR_CLEAR:    rdata_q <= {2'h0, clear_q};
            ADDR_EVENT_LO: begin
               rdata_q <= event_q[7:0];
               rhold_q <= event_q[15:8];
            end
            default:       rdata_q <= is_msb(addr_q) ? rhold_q : 8'h00;
         endcase
      end
   end

   //==========================================================================
   // ready handshake
   scc_dev_st_e st_q;
   logic [1:0]  cnt_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_q  <= DS_IDLE;
         cnt_q <= '0;
      end else begin
         case (st_q)
            DS_IDLE: begin
               if (wr_fall || rd_fall) begin
                  st_q  <= DS_LOW;
                  cnt_q <= 2'(RDY_LOW_CYC - 1);
               end
            end
            DS_LOW: begin
               if (cnt_q == 2'h0) st_q <= DS_HOLD;
               else cnt_q <= cnt_q - 2'h1;
            end
            DS_HOLD: begin
               if ((wr_f && rd_f) || cs_f) st_q <= DS_IDLE;
            end
            default: st_q <= DS_IDLE;
         endcase
      end
   end

   // pin drivers, all from flops
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         bus.rdy_d    <= 1'b1;
         bus.rdy_d_oe <= 1'b0;
         bus.ad_d     <= '0;
         bus.ad_d_oe  <= 1'b0;
      end else begin
         bus.rdy_d_oe <= !cs_f;
         bus.rdy_d    <= !(wr_fall || rd_fall || st_q == DS_LOW);
         bus.ad_d     <= rdata_q;
         bus.ad_d_oe  <= !cs_f && !rd_f && (st_q != DS_IDLE);
      end
   end

   //==========================================================================
   // activity monitor
   scc_bucket #(.CYC_PER_MS(CYC_PER_MS)) scc_bucket_i (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .act_i   (act_f && !fp_q[0]),
      .fill_i  (fill_q),
      .leak_i  (leak_q),
      .cap_i   (cap_q),
      .raise_i (raise_q),
      .clear_i (clear_q),
      .alarm_o (alarm)
   );

   // user-side outputs
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         primary_skew_o   <= RST_SKEW;
         secondary_skew_o <= RST_SKEW;
         alarm_o          <= 1'b0;
         event_o          <= '0;
      end else begin
         primary_skew_o   <= pskew_q;
         secondary_skew_o <= sskew_q;
         alarm_o          <= alarm;
         event_o          <= event_q;
      end
   end
endmodule : scc_dev

// ---- hdl/scc_host.sv ----
// host end: drives single-byte multiplexed bus cycles
`timescale 1ns/100ps
module scc_host (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   scc_bus_if.host         bus,
   input  wire logic       req_i,
   input  wire logic       we_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic            busy_o,
   output logic            done_o,
   output logic [7:0]      rdata_o
);
   import scc_pkg::*;
   // ready and data pins pass the 3-flop filter
   logic [8:0] s1_q;
   logic [8:0] s2_q;
   logic [8:0] s3_q;
   logic [8:0] f_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s1_q <= 9'h1FF;
         s2_q <= 9'h1FF;
         s3_q <= 9'h1FF;
         f_q  <= 9'h1FF;
      end else begin
         s1_q <= {bus.rdy, bus.ad};
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q  <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
      end
   end

   scc_host_st_e st_q;
   logic [2:0]   cnt_q;
   logic         we_q;
   logic [7:0]   wd_q;
   // the caller orders multibyte bytes itself: low byte first
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_q               <= HS_IDLE;
         cnt_q              <= '0;
         we_q               <= 1'b0;
         wd_q               <= '0;
         bus.ale            <= 1'b0;
         bus.cs_n           <= 1'b1;
         bus.write_strobe_n <= 1'b1;
         bus.read_strobe_n  <= 1'b1;
         bus.ad_h           <= '0;
         bus.ad_h_oe        <= 1'b0;
         busy_o             <= 1'b0;
         done_o             <= 1'b0;
         rdata_o            <= '0;
      end else begin
         done_o <= 1'b0;
         if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
         case (st_q)
            HS_IDLE: begin
               if (req_i) begin
                  we_q        <= we_i;
                  wd_q        <= wdata_i;
                  busy_o      <= 1'b1;
                  bus.cs_n    <= 1'b0;
                  bus.ale     <= 1'b1;
                  bus.ad_h    <= addr_i;
                  bus.ad_h_oe <= 1'b1;
                  cnt_q       <= 3'(PIN_HOLD_CYC - 1);
                  st_q        <= HS_ALE;
               end
            end
            HS_ALE: begin
               if (cnt_q == 3'h0) begin
                  bus.ale <= 1'b0;
                  cnt_q   <= 3'(PIN_HOLD_CYC - 1);
                  st_q    <= HS_AHOLD;
               end
            end
            HS_AHOLD: begin
               if (cnt_q == 3'h0) begin
                  bus.ad_h    <= wd_q;
                  bus.ad_h_oe <= we_q;
                  cnt_q       <= 3'(PIN_HOLD_CYC - 1);
                  st_q        <= HS_SETUP;
               end
            end
            HS_SETUP: begin
               // strobe only after the latch strobe has fallen
               if (cnt_q == 3'h0) begin
                  bus.write_strobe_n <= !we_q;
                  bus.read_strobe_n  <= we_q;
                  st_q               <= HS_WAITLO;
               end
            end
            HS_WAITLO: begin
               if (!f_q[8]) st_q <= HS_WAITHI;
            end
            HS_WAITHI: begin
               // strobe stays low until ready rises again
               if (f_q[8]) begin
                  if (!we_q) rdata_o <= f_q[7:0];
                  bus.write_strobe_n <= 1'b1;
                  bus.read_strobe_n  <= 1'b1;
                  st_q               <= HS_CSH;
               end
            end
            HS_CSH: begin
               bus.cs_n    <= 1'b1;
               bus.ad_h_oe <= 1'b0;
               done_o      <= 1'b1;
               // gap also covers the device's filter delay in releasing the bus
               cnt_q       <= 3'(CS_GAP_CYC + PIN_HOLD_CYC - 1);
               st_q        <= HS_GAP;
            end
            HS_GAP: begin
               if (cnt_q == 3'h0) begin
                  busy_o <= 1'b0;
                  st_q   <= HS_IDLE;
               end
            end
            default: st_q <= HS_IDLE;
         endcase
      end
   end
endmodule : scc_host

// ---- tb/scc_bus_checker.sv ----
// handshake checker for the multiplexed register bus
`timescale 1ns/100ps
module scc_bus_checker (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ale,
   input wire logic cs_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic ad_d_oe,
   input wire logic rdy_d,
   input wire logic rdy_d_oe,
   input wire logic rdy
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   //=====
   // device ready pulse
   rdy_low_len_a: assert property ($fell(rdy_d) |-> !rdy_d [*2]) else $error("ready low too short");
   rdy_low_end_a: assert property ($fell(rdy_d) |-> ##[2:6] rdy_d) else $error("ready stuck low");
   rdy_cause_a: assert property ($fell(rdy_d) |-> !cs_n && !(write_strobe_n && read_strobe_n))
      else $error("ready low without strobe");
   rdy_answer_a: assert property ($fell(write_strobe_n) |-> ##[1:10] !rdy) else $error("no ready pulse");
   // host keeps strobe until ready returns; a short strobe would lose the write
   strobe_hold_a: assert property (!write_strobe_n && !rdy |=> !write_strobe_n)
      else $error("strobe left early");
   strobe_after_ale_a: assert property ($fell(write_strobe_n) || $fell(read_strobe_n) |-> !ale && !cs_n)
      else $error("strobe before address latch");
   //=====
   // ready drive window follows chip select
   rdy_drive_a: assert property ($fell(cs_n) |-> ##[1:8] rdy_d_oe) else $error("ready not driven");
   rdy_release_a: assert property ($rose(cs_n) |-> ##[1:8] !rdy_d_oe) else $error("ready not released");
   idle_quiet_a: assert property (cs_n [*8] |-> !rdy_d_oe && !ad_d_oe) else $error("bus driven idle");
   read_data_a: assert property ($rose(rdy_d) && !read_strobe_n |-> ad_d_oe) else $error("no read data");
   // main scenarios
   cover property ($fell(write_strobe_n));
   cover property ($fell(read_strobe_n));
   cover property ($rose(cs_n));
endmodule : scc_bus_checker

// ---- tb/test_sync_clock_config_registers.sv ----
// self-checking bench: host end and device end joined on one bus
`timescale 1ns/100ps
module test_sync_clock_config_registers;
   import scc_pkg::*;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        req = 1'b0;
   logic        we = 1'b0;
   logic        act = 1'b0;
   logic        toggling = 1'b0;
   logic [1:0]  pins = 2'b10;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        busy, alarm, done;
   logic [7:0]  rdata;
   logic [11:0] pskew, sskew;
   logic [15:0] ev;
   int          miscompares = 0;
   int          tests_run = 0;
   logic [7:0]  ra [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
                            8'h0B, 8'h0C, 8'h0D, 8'h20};
   logic [7:0]  re [15] = '{8'h34, 8'h12, 8'h5A, 8'h06, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03,
                            8'h14, 8'h0F, 8'h0A, 8'h00};
   // threshold writes: refused orderings first, then values that stand; fill and leak writes last, cut to 4 bits
   logic [7:0]  ta [11] = '{8'h0B, 8'h0D, 8'h0C, 8'h0C, 8'h0C, 8'h0D, 8'h0D, 8'h0C, 8'h09, 8'h0A, 8'h09};
   logic [7:0]  td [11] = '{8'h0E, 8'h0F, 8'h0A, 8'h15, 8'h14, 8'h13, 8'h02, 8'h04, 8'h1F, 8'h1F, 8'h00};
   logic [7:0]  te [11] = '{8'h14, 8'h0A, 8'h0F, 8'h0F, 8'h14, 8'h13, 8'h02, 8'h04, 8'h0F, 8'h0F, 8'h00};
   scc_bus_if scc_bus_if_i ();
   always #20 clk_i = ~clk_i;
   // short millisecond keeps the monitor windows to tens of cycles; id values are arbitrary
   scc_dev #(.CYC_PER_MS(10), .DEVICE_ID(16'h1234), .SI_REV(8'h5A), .SI_SUBREV(8'h06)) scc_dev_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .bus(scc_bus_if_i), .role_select_pins_i(pins), .activity_i(act),
      .primary_skew_o(pskew), .secondary_skew_o(sskew), .alarm_o(alarm), .event_o(ev));
   scc_host scc_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(scc_bus_if_i), .req_i(req), .we_i(we),
      .addr_i(addr), .wdata_i(wdata), .busy_o(busy), .done_o(done), .rdata_o(rdata));
   scc_bus_checker scc_bus_checker_i (.clk_i(clk_i), .nrst_i(nrst_i), .ale(scc_bus_if_i.ale),
      .cs_n(scc_bus_if_i.cs_n), .write_strobe_n(scc_bus_if_i.write_strobe_n),
      .read_strobe_n(scc_bus_if_i.read_strobe_n), .ad_d_oe(scc_bus_if_i.ad_d_oe),
      .rdy_d(scc_bus_if_i.rdy_d), .rdy_d_oe(scc_bus_if_i.rdy_d_oe), .rdy(scc_bus_if_i.rdy));
   // activity toggles every fourth cycle: the pin filter drops a level held one cycle,
   // and a rising edge every eight cycles still lands in each ten-cycle fill window
   always begin
      @(posedge clk_i) #1;
      if (toggling) act = ~act;
      repeat (3) @(posedge clk_i);
   end
   //=====
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   // one host cycle; the host end does the bus handshake itself
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      int nd;
      nd = 0;
      @(posedge clk_i) #1;
      req = 1'b1;
      we = w;
      addr = a;
      wdata = d;
      @(posedge clk_i) #1;
      req = 1'b0;
      for (k = 0; busy !== 1'b0; k++) begin
         if (done === 1'b1) nd++;
         if (k > 300) begin
            miscompares++;
            tally_and_finish();
         end
         @(posedge clk_i) #1;
      end
      chk("done pulse", 16'(nd), 16'h0001);
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
   endtask : rd
   task automatic wait_alarm(input logic lv);
      int k;
      for (k = 0; alarm !== lv; k++) begin
         if (k > 5000) begin
            miscompares++;
            tally_and_finish();
         end
         @(posedge clk_i) #1;
      end
      // the event register copy trails the alarm output by one cycle
      @(posedge clk_i) #1;
   endtask : wait_alarm
   //=====
   initial begin
      repeat (10) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      foreach (ra[i]) rd(ra[i], re[i]);
      // role pins, their event and write-one-to-clear on the top byte only
      pins = 2'b01;
      acc(1'b1, ADDR_ROLE, 8'hFF);
      rd(ADDR_ROLE, 8'h01);
      chk("role event", {15'h0, ev[EV_ROLE_CHG]}, 16'h0001);
      acc(1'b1, ADDR_EVENT_LO, 8'h04);
      chk("role event", {15'h0, ev[EV_ROLE_CHG]}, 16'h0001);
      acc(1'b1, ADDR_EVENT_HI, 8'h00);
      chk("role event", {15'h0, ev[EV_ROLE_CHG]}, 16'h0000);
      // skew registers commit only on the top byte
      acc(1'b1, ADDR_PSKEW_LO, 8'h34);
      chk("primary skew", {4'h0, pskew}, 16'h0000);
      acc(1'b1, ADDR_PSKEW_HI, 8'hAB);
      chk("primary skew", {4'h0, pskew}, 16'h0B34);
      acc(1'b1, ADDR_SSKEW_LO, 8'hFF);
      acc(1'b1, ADDR_SSKEW_HI, 8'hFF);
      chk("secondary skew", {4'h0, sskew}, 16'h0FFF);
      rd(ADDR_PSKEW_LO, 8'h34);
      rd(ADDR_PSKEW_HI, 8'h0B);
      rd(ADDR_SSKEW_LO, 8'hFF);
      rd(ADDR_SSKEW_HI, 8'h0F);
      foreach (ta[i]) begin
         acc(1'b1, ta[i], td[i]);
         rd(ta[i], te[i]);
      end
      // quiet reference raises the alarm, steady activity leaks it away
      wait_alarm(1'b1);
      chk("alarm on event", {15'h0, ev[EV_ALARM_ON]}, 16'h0001);
      toggling = 1'b1;
      wait_alarm(1'b0);
      chk("alarm off event", {15'h0, ev[EV_ALARM_OFF]}, 16'h0001);
      acc(1'b1, ADDR_EVENT_LO, 8'h03);
      acc(1'b1, ADDR_EVENT_HI, 8'h00);
      rd(ADDR_EVENT_LO, 8'h00);
      chk("events", ev, 16'h0000);
      tally_and_finish();
   end
endmodule : test_sync_clock_config_registers
